// *** pkg/nvc_defs.svh ***
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Array geometry
`define NVC_AW 7
`define NVC_ERASED 8'hFF

////////////////////////////////////////////////////////////////////////////////
// CPU I/O register selects
`define NVC_IO_INDEX 2'h0
`define NVC_IO_VALUE 2'h1
`define NVC_IO_CONTROL 2'h2

// Control register bit positions
`define NVC_CTL_RE 0
`define NVC_CTL_PE 1
`define NVC_CTL_MWE 2
`define NVC_CTL_RIE 3
`define NVC_CTL_PM_LO 4
`define NVC_CTL_PM_HI 5

////////////////////////////////////////////////////////////////////////////////
// Timing
`define NVC_MWE_WINDOW 3'h4
`define NVC_STALL_WRITE 3'h2
`define NVC_STALL_READ 3'h4
`define NVC_PCLK_MHZ 25
`define NVC_OSC_MHZ 1
`define NVC_T_ATOMIC_US 3400
`define NVC_T_SPLIT_US 1800

////////////////////////////////////////////////////////////////////////////////
// Controller APB register offsets
`define NVC_APB_CFG 12'h000
`define NVC_APB_ADDR 12'h004
`define NVC_APB_DATA 12'h008
`define NVC_APB_CMD 12'h00C
`define NVC_APB_STATUS 12'h010
`define NVC_CMD_READ 0
`define NVC_CMD_PROG 1
`define NVC_CFG_GIE 2
`define NVC_CFG_RIE 3

`endif

// *** pkg/nvc_pkg.sv ***
package nvc_pkg;

  // Programming modes selected by the mode bits
  typedef enum logic [1:0] {
    NVC_PM_ATOMIC = 2'h0,
    NVC_PM_ERASE = 2'h1,
    NVC_PM_WRITE = 2'h2,
    NVC_PM_RSVD = 2'h3
  } nvc_pm_t;

  // Controller sequencer states
  typedef enum logic [8:0] {
    NVC_S_IDLE = 9'h001,
    NVC_S_POLL = 9'h002,
    NVC_S_POLL_CHK = 9'h004,
    NVC_S_LD_ADDR = 9'h008,
    NVC_S_LD_DATA = 9'h010,
    NVC_S_ARM = 9'h020,
    NVC_S_FIRE = 9'h040,
    NVC_S_RD_VAL = 9'h080,
    NVC_S_RD_CHK = 9'h100
  } nvc_state_t;

endpackage

// *** pkg/nvc_if.sv ***
`timescale 1ns/1ns
interface nvc_if;
  logic [1:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic stall;
  logic irq;
  logic gie;

  // Storage end
  modport dev (
    input addr,
    input wr,
    input rd,
    input wdata,
    input gie,
    output rdata,
    output stall,
    output irq
  );

  // CPU end
  modport cpu (
    output addr,
    output wr,
    output rd,
    output wdata,
    output gie,
    input rdata,
    input stall,
    input irq
  );
endinterface

// *** hdl/nvc_prog_timer.sv ***
`timescale 1ns/1ns
module nvc_prog_timer #(
  parameter int PRESCALE = 25,
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [TW-1:0] ticks,
  // Status
  output logic done
);
  localparam logic [7:0] PRE_TOP = 8'(PRESCALE - 1);

  if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_pre
    $error("nvc_prog_timer: PRESCALE out of range");
  end

  logic [7:0] pre_ff;
  logic [TW-1:0] cnt_ff;
  logic done_ff;

  // Oscillator tick stands in for the calibrated RC clock
  wire running = cnt_ff != '0;
  wire osc_tick = running && pre_ff == 8'h00;
  wire last = osc_tick && cnt_ff == TW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and duration down-counter
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 8'h00;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      pre_ff <= (load || osc_tick) ? PRE_TOP : pre_ff - 8'h01;
      cnt_ff <= load ? ticks : (osc_tick ? cnt_ff - TW'(1) : cnt_ff);
      done_ff <= last;
    end
  end

  assign done = done_ff;
endmodule

// *** hdl/nvc_device.sv ***
`timescale 1ns/1ns
`include "nvc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - 128 separate byte cells, index 0..127
// - Index bits 6..0, bit 7 reads zero
// - Software loads index before any access
// - Value register: byte to store, byte fetched
// - Control bits 7..6 read zero
// - Mode: atomic 3.4ms, erase 1.8ms, write 1.8ms
// - Mode writes ignored while write strobe set
// - Reset clears mode unless programming
// - Ready interrupt level while idle and enabled
// - Master write enable self-clears after four cycles
// - Write strobe starts only within enable window
// - Write strobe held until programming time elapses
// - Write start stalls CPU two cycles
// - Read fetches byte, stalls CPU four cycles
// - Busy refuses reads and index changes
// - No new operation until current completes
// - Software polls write strobe before reading
// - Write-only programs without erasing first
// - Durations timed by calibrated oscillator; here pclk divided by PRESCALE stands in
// - Software program sequence, interrupts held off
// - Programming survives system reset to completion; power-on reset aborts it
// - Interrupt needs own and global enable
module nvc_device
  import nvc_pkg::*;
#(
  parameter int AW = `NVC_AW,
  parameter int PRESCALE = `NVC_PCLK_MHZ / `NVC_OSC_MHZ,
  parameter int ATOMIC_TICKS = `NVC_T_ATOMIC_US * `NVC_OSC_MHZ,
  parameter int SPLIT_TICKS = `NVC_T_SPLIT_US * `NVC_OSC_MHZ
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // CPU side
  nvc_if.dev io,
  // Status
  output logic busy
);
  localparam int DEPTH = 1 << AW;
  localparam int TW = 16;

  if (AW != 7) begin : g_bad_aw
    $error("nvc_device: index field is seven bits");
  end
  if (ATOMIC_TICKS < 1 || SPLIT_TICKS < 1 || ATOMIC_TICKS >= (1 << TW)
      || SPLIT_TICKS >= (1 << TW)) begin : g_bad_ticks
    $error("nvc_device: programming tick counts out of range");
  end

  // Nonvolatile array, never reset
  logic [7:0] mem [DEPTH];

  // CPU-facing registers (system reset)
  logic [AW-1:0] index_ff;
  logic [7:0] value_ff;
  logic rie_ff;
  logic [2:0] mwe_cnt_ff;
  logic re_ff;
  logic [2:0] stall_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;

  // Programming engine (power-on reset; mode bits also cleared by system reset while idle)
  logic pe_ff;
  nvc_pm_t pm_ff;
  nvc_pm_t op_pm_ff;
  logic [AW-1:0] op_addr_ff;
  logic [7:0] op_data_ff;
  logic done;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire wr_index = io.wr && io.addr == `NVC_IO_INDEX;
  wire wr_value = io.wr && io.addr == `NVC_IO_VALUE;
  wire wr_ctl = io.wr && io.addr == `NVC_IO_CONTROL;
  wire mwe_open = mwe_cnt_ff != 3'h0;
  wire pm_req_rsvd = pm_ff == NVC_PM_RSVD;
  // Reserved mode is refused rather than guessed at
  wire start = wr_ctl && io.wdata[`NVC_CTL_PE] && mwe_open && !pe_ff && !pm_req_rsvd;
  wire rd_start = wr_ctl && io.wdata[`NVC_CTL_RE] && !pe_ff && !start;
  wire index_we = wr_index && !pe_ff;
  wire pm_we = wr_ctl && !pe_ff;
  wire [TW-1:0] load_ticks = (pm_ff == NVC_PM_ATOMIC) ? TW'(ATOMIC_TICKS) : TW'(SPLIT_TICKS);

  // Cell value after the operation finishes
  logic [7:0] cell_now;
  logic [7:0] nxt_cell;
  assign cell_now = mem[op_addr_ff];
  always_comb begin
    case (op_pm_ff)
      NVC_PM_ATOMIC: nxt_cell = op_data_ff;
      NVC_PM_ERASE: nxt_cell = `NVC_ERASED;
      NVC_PM_WRITE: nxt_cell = cell_now & op_data_ff;
      default: nxt_cell = cell_now;
    endcase
  end

  // Register readback; reserved bits zero
  logic [7:0] nxt_rdata;
  wire [7:0] ctl_view = {2'b00, pm_ff, rie_ff, mwe_open, pe_ff, re_ff};
  always_comb begin
    case (io.addr)
      `NVC_IO_INDEX: nxt_rdata = {1'b0, index_ff};
      `NVC_IO_VALUE: nxt_rdata = value_ff;
      `NVC_IO_CONTROL: nxt_rdata = ctl_view;
      default: nxt_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duration timer on the oscillator tick, never on raw CPU cycles
  nvc_prog_timer #(
    .PRESCALE(PRESCALE),
    .TW(TW)
  ) u_timer (
    .pclk(pclk),
    .rst_n(por_n),
    .load(start),
    .ticks(load_ticks),
    .done(done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe and latched operation; system reset does not abort it
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pe_ff <= 1'b0;
      op_pm_ff <= NVC_PM_ATOMIC;
      op_addr_ff <= '0;
      op_data_ff <= 8'h00;
    end else begin
      if (start) begin
        pe_ff <= 1'b1;
        op_pm_ff <= pm_ff;
        op_addr_ff <= index_ff;
        op_data_ff <= value_ff;
      end else if (done) begin
        pe_ff <= 1'b0;
      end
    end
  end

  // Mode bits: cleared by system reset only while idle
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pm_ff <= NVC_PM_ATOMIC;
    end else if (!presetn) begin
      pm_ff <= pe_ff ? pm_ff : NVC_PM_ATOMIC;
    end else if (pm_we) begin
      pm_ff <= nvc_pm_t'(io.wdata[`NVC_CTL_PM_HI:`NVC_CTL_PM_LO]);
    end
  end

  // Array update at the end of the programming time
  always_ff @(posedge pclk) begin
    if (done) begin
      mem[op_addr_ff] <= nxt_cell;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index and value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_ff <= '0;
      value_ff <= 8'h00;
    end else begin
      if (index_we) begin
        index_ff <= io.wdata[AW-1:0];
      end
      if (rd_start) begin
        value_ff <= mem[index_ff];
      end else if (wr_value) begin
        value_ff <= io.wdata;
      end
    end
  end

  // Unlock window, read strobe and CPU stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rie_ff <= 1'b0;
      mwe_cnt_ff <= 3'h0;
      re_ff <= 1'b0;
      stall_ff <= 3'h0;
    end else begin
      if (wr_ctl) begin
        rie_ff <= io.wdata[`NVC_CTL_RIE];
      end
      if (wr_ctl && io.wdata[`NVC_CTL_MWE]) begin
        mwe_cnt_ff <= `NVC_MWE_WINDOW;
      end else if (mwe_open) begin
        mwe_cnt_ff <= mwe_cnt_ff - 3'h1;
      end
      if (start) begin
        stall_ff <= `NVC_STALL_WRITE;
      end else if (rd_start) begin
        stall_ff <= `NVC_STALL_READ;
      end else if (stall_ff != 3'h0) begin
        stall_ff <= stall_ff - 3'h1;
      end
      if (rd_start) begin
        re_ff <= 1'b1;
      end else if (stall_ff == 3'h1) begin
        re_ff <= 1'b0;
      end
    end
  end

  // Readback and level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      irq_ff <= rie_ff && io.gie && !pe_ff;
    end
  end

  // The CPU end is expected to issue nothing while stalled
  assign io.stall = stall_ff != 3'h0;
  assign io.rdata = rdata_ff;
  assign io.irq = irq_ff;
  assign busy = pe_ff;
endmodule

// *** hdl/nvc_host.sv ***
`timescale 1ns/1ns
`include "nvc_defs.svh"
module nvc_host
  import nvc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Storage side
  nvc_if.cpu io
);
  logic [3:0] cfg_ff;
  logic [6:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] rbyte_ff;
  logic is_read_ff;
  nvc_state_t state_ff;
  nvc_state_t nxt_state;
  logic [31:0] prdata_ff;
  logic slverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire idle = state_ff == NVC_S_IDLE;
  wire mapped = paddr == `NVC_APB_CFG || paddr == `NVC_APB_ADDR || paddr == `NVC_APB_DATA
                || paddr == `NVC_APB_CMD || paddr == `NVC_APB_STATUS;
  wire cmd_wr = wr_acc && paddr == `NVC_APB_CMD && idle;
  wire go_read = cmd_wr && pwdata[`NVC_CMD_READ];
  wire go_prog = cmd_wr && pwdata[`NVC_CMD_PROG] && !pwdata[`NVC_CMD_READ];
  wire [31:0] status = {16'h0000, rbyte_ff, 5'h00, io.stall, io.irq, !idle};
  wire [31:0] rd_mux = paddr == `NVC_APB_CFG ? {28'h0000_000, cfg_ff} :
                       paddr == `NVC_APB_ADDR ? {25'h000_0000, addr_ff} :
                       paddr == `NVC_APB_DATA ? {24'h00_0000, data_ff} :
                       paddr == `NVC_APB_STATUS ? status : 32'h0000_0000;

  // Control byte base: mode and ready interrupt enable kept every write
  wire [7:0] ctl_base = {2'b00, cfg_ff[1:0], cfg_ff[`NVC_CFG_RIE], 3'b000};
  wire [7:0] ctl_fire = ctl_base | (is_read_ff ? 8'h01 : 8'h02);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state; issuing states hold while the CPU is stalled
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      NVC_S_IDLE: nxt_state = (go_read || go_prog) ? NVC_S_POLL : NVC_S_IDLE;
      NVC_S_POLL: nxt_state = io.stall ? NVC_S_POLL : NVC_S_POLL_CHK;
      // Wait out any programming before touching index or value
      NVC_S_POLL_CHK: nxt_state = io.rdata[`NVC_CTL_PE] ? NVC_S_POLL : NVC_S_LD_ADDR;
      NVC_S_LD_ADDR: nxt_state = io.stall ? NVC_S_LD_ADDR :
                                 (is_read_ff ? NVC_S_FIRE : NVC_S_LD_DATA);
      NVC_S_LD_DATA: nxt_state = io.stall ? NVC_S_LD_DATA : NVC_S_ARM;
      NVC_S_ARM: nxt_state = io.stall ? NVC_S_ARM : NVC_S_FIRE;
      NVC_S_FIRE: nxt_state = io.stall ? NVC_S_FIRE : (is_read_ff ? NVC_S_RD_VAL : NVC_S_IDLE);
      NVC_S_RD_VAL: nxt_state = io.stall ? NVC_S_RD_VAL : NVC_S_RD_CHK;
      NVC_S_RD_CHK: nxt_state = NVC_S_IDLE;
      default: nxt_state = NVC_S_IDLE;
    endcase
  end

  // I/O request drive from state
  wire issue_wr = (state_ff == NVC_S_LD_ADDR || state_ff == NVC_S_LD_DATA
                   || state_ff == NVC_S_ARM || state_ff == NVC_S_FIRE) && !io.stall;
  wire issue_rd = (state_ff == NVC_S_POLL || state_ff == NVC_S_RD_VAL) && !io.stall;
  assign io.wr = issue_wr;
  assign io.rd = issue_rd;
  assign io.addr = (state_ff == NVC_S_LD_ADDR) ? `NVC_IO_INDEX :
                   (state_ff == NVC_S_LD_DATA || state_ff == NVC_S_RD_VAL) ? `NVC_IO_VALUE :
                   `NVC_IO_CONTROL;
  assign io.wdata = (state_ff == NVC_S_LD_ADDR) ? {1'b0, addr_ff} :
                    (state_ff == NVC_S_LD_DATA) ? data_ff :
                    (state_ff == NVC_S_ARM) ? (ctl_base | 8'h04) :
                    (state_ff == NVC_S_FIRE) ? ctl_fire : ctl_base;
  // Global enable held off for the whole timed sequence
  assign io.gie = cfg_ff[`NVC_CFG_GIE] && idle;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 4'h0;
      addr_ff <= 7'h00;
      data_ff <= 8'h00;
      is_read_ff <= 1'b0;
      state_ff <= NVC_S_IDLE;
    end else begin
      if (wr_acc && paddr == `NVC_APB_CFG) begin
        cfg_ff <= pwdata[3:0];
      end
      if (wr_acc && paddr == `NVC_APB_ADDR) begin
        addr_ff <= pwdata[6:0];
      end
      if (wr_acc && paddr == `NVC_APB_DATA) begin
        data_ff <= pwdata[7:0];
      end
      if (go_read || go_prog) begin
        is_read_ff <= go_read;
      end
      state_ff <= nxt_state;
    end
  end

  // Fetched byte and APB read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbyte_ff <= 8'h00;
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else begin
      if (state_ff == NVC_S_RD_CHK) begin
        rbyte_ff <= io.rdata;
      end
      if (setup) begin
        prdata_ff <= rd_mux;
        slverr_ff <= !mapped;
      end
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = slverr_ff;
endmodule

// *** verif/nvc_asserts.sv ***
`timescale 1ns/1ns
module nvc_asserts #(
  parameter int PRESCALE = 2,
  parameter int ATOMIC_TICKS = 8,
  parameter int SPLIT_TICKS = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Interface signals
  input wire logic [1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic stall,
  input wire logic irq,
  input wire logic gie,
  // Storage status
  input wire logic busy
);
  // Margin of 4 lets the prescaler phase and the start latency float
  localparam int T_ATOM = ATOMIC_TICKS * PRESCALE - 4;
  localparam int T_SPLIT = SPLIT_TICKS * PRESCALE - 4;
  logic [2:0] win_ff;
  logic rie_ff;
  wire [2:0] nxt_win;
  wire nxt_rie;
  // Decode of control writes, as the storage end sees them
  wire ctl_wr = wr && (addr == 2'h2);
  wire arm_hit = ctl_wr && wdata[2];
  wire prog_go = ctl_wr && wdata[1] && (win_ff != 3'h0) && !busy && (wdata[5:4] != 2'h3);
  wire read_go = ctl_wr && wdata[0] && !busy && !prog_go;
  assign nxt_win = arm_hit ? 3'h4 : ((win_ff != 3'h0) ? win_ff - 3'h1 : 3'h0);
  assign nxt_rie = ctl_wr ? wdata[3] : rie_ff;
  // Shadow of unlock window and ready enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_ff <= 3'h0;
      rie_ff <= 1'b0;
    end else begin
      win_ff <= nxt_win;
      rie_ff <= nxt_rie;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stall_two;
    busy && stall ##1 stall ##1 !stall;
  endsequence
  sequence s_stall_four;
    stall [*4] ##1 !stall;
  endsequence
  a_prog_stall_two: assert property (prog_go |=> s_stall_two)
    else $error("program start stall wrong");
  a_read_stall_four: assert property (read_go |=> s_stall_four)
    else $error("read stall wrong");
  a_atomic_time: assert property (prog_go && wdata[5:4] == 2'h0 |=> busy ##T_ATOM busy ##[1:8] !busy)
    else $error("atomic duration wrong");
  a_split_time: assert property (prog_go && wdata[5:4] != 2'h0 |=> busy ##T_SPLIT busy ##[1:8] !busy)
    else $error("split duration wrong");
  a_busy_cause: assert property ($rose(busy) |-> $past(prog_go))
    else $error("busy without unlocked strobe");
  a_irq_level: assert property (irq == $past(rie_ff && gie && !busy))
    else $error("ready interrupt level wrong");
  a_ctl_readback: assert property ($past(presetn) && $past(addr) == 2'h2 |-> rdata[7:6] == 2'h0 && rdata[1] == $past(busy))
    else $error("control readback wrong");
  a_index_rsvd: assert property ($past(presetn) && $past(addr) == 2'h0 |-> !rdata[7])
    else $error("index bit 7 not zero");
  a_stall_quiet: assert property (stall |-> !wr)
    else $error("access issued during stall");
  a_poll_quiet: assert property (rd |-> !wr && !stall)
    else $error("read request during write or stall");
endmodule

// *** verif/tb_eeprom_byte_access_controller.sv ***
`timescale 1ns/1ns
`include "nvc_defs.svh"
module tb_eeprom_byte_access_controller;
  localparam int PS = 2;
  localparam int AT = 8;
  localparam int ST = 4;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, busy, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [7:0] mem [128];
  logic [7:0] d;
  logic [1:0] mtab [6];
  logic [6:0] atab [6];
  int n_mismatch, cmp_count;
  nvc_if bus ();
  nvc_device #(.PRESCALE(PS), .ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) nvc_device_i (.pclk(pclk),
    .presetn(presetn), .por_n(por_n), .io(bus.dev), .busy(busy));
  nvc_host nvc_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .io(bus.cpu));
  nvc_asserts #(.PRESCALE(PS), .ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) nvc_asserts_i (.pclk(pclk),
    .presetn(presetn), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata),
    .rdata(bus.rdata), .stall(bus.stall), .irq(bus.irq), .gie(bus.gie), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the wait has no bound of its own, the watchdog cuts it
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rv);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one command and wait for the sequencer, then update the model
  task automatic op(input logic [1:0] m, input logic [6:0] a, input logic [7:0] dv,
    input logic rd_op, input logic [1:0] ie);
    int k;
    apb(`NVC_APB_CFG, 1'b1, {28'h0000_000, ie, m}, st);
    apb(`NVC_APB_ADDR, 1'b1, {25'h0, a}, st);
    apb(`NVC_APB_DATA, 1'b1, {24'h00_0000, dv}, st);
    apb(`NVC_APB_CMD, 1'b1, rd_op ? 32'h0000_0001 : 32'h0000_0002, st);
    for (k = 0; k < 300; k++) begin
      apb(`NVC_APB_STATUS, 1'b0, 32'h0000_0000, st);
      if (st[0] === 1'b0) break;
    end
    // A sequencer that never returns to idle counts as a mismatch
    chk({31'h0, st[0]}, 32'h0000_0000);
    if (!rd_op) begin
      case (m)
        2'h0: mem[a] = dv;
        2'h1: mem[a] = 8'hff;
        2'h2: mem[a] = mem[a] & dv;
        default: ;
      endcase
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [1:0] ie);
    op(2'h0, a, 8'h00, 1'b1, ie);
    apb(`NVC_APB_STATUS, 1'b0, 32'h0000_0000, st);
    chk({24'h00_0000, st[15:8]}, {24'h00_0000, mem[a]});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog, far beyond the longest expected run
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    cmp_count = 0;
    mtab = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h3};
    atab = '{7'h7f, 7'h7f, 7'h7f, 7'h00, 7'h00, 7'h00};
    d = 8'($urandom(32'h0000_bc08));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    // Every mode, boundary cells, reserved mode refused
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      op(mtab[i], atab[i], d, 1'b0, 2'h0);
      rd_chk(atab[i], 2'h0);
    end
    // Unmapped address
    apb(12'h014, 1'b1, 32'hffff_ffff, st);
    apb(12'h014, 1'b0, 32'h0000_0000, st);
    chk(st, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // Reset in mid-programming, then read with polling
    d = 8'($urandom);
    op(2'h0, 7'h05, d, 1'b0, 2'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, busy}, 32'h0000_0001);
    presetn <= 1'b1;
    rd_chk(7'h05, 2'h0);
    // Ready interrupt needs both enables
    for (int j = 1; j < 4; j++) begin
      rd_chk(7'h05, 2'(j));
      apb(`NVC_APB_STATUS, 1'b0, 32'h0000_0000, st);
      chk({31'h0, st[1]}, {31'h0, j == 3});
    end
    conclude();
  end
endmodule
